// >>> hdl/dma_irq_pkg.sv
// Package: register map, field layout and reset values of the DMA event clear block.
// Assumes a 32-bit APB slave with one aligned word per register.
package dma_irq_pkg;
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 13;
  localparam int          DONE_MAX        = 16;
  localparam int          WARN_N          = 8;
  localparam int          EVT_W           = 26;
  localparam int          WARN_LSB        = 16;
  localparam int          ADDR_FAULT_BIT  = 24;
  localparam int          DATA_FAULT_BIT  = 25;
  localparam logic [12:0] OFS_RAW_STATUS  = 13'h1030;
  localparam logic [12:0] OFS_MASK        = 13'h1028;
  localparam logic [12:0] OFS_MASKED      = 13'h1038;
  localparam logic [12:0] OFS_CLEAR       = 13'h1048;
  localparam logic [31:0] CLEAR_RESET     = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET      = 32'h0000_0000;
  localparam logic [25:0] EVT_ZERO        = 26'h000_0000;
  localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
endpackage

// >>> hdl/apb_decode.sv
// APB slave front end: zero-wait access, one-cycle write and read strobes.
// Assumes an APB master on mclk; unmapped addresses answer with pslverr.
`timescale 1ns/1ps
module apb_decode
  import dma_irq_pkg::*;
(
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   wr_mask,
  output logic                   wr_clear,
  output logic                   rd_hit
);
  logic access;
  logic mapped;
  assign access   = psel && penable;
  assign mapped   = (paddr == OFS_MASK) || (paddr == OFS_RAW_STATUS) ||
                    (paddr == OFS_MASKED) || (paddr == OFS_CLEAR);
  assign pready   = psel;
  assign pslverr  = access && !mapped;
  assign wr_mask  = access && pwrite && (paddr == OFS_MASK);
  assign wr_clear = access && pwrite && (paddr == OFS_CLEAR);
  assign rd_hit   = access && !pwrite && mapped;
endmodule

// >>> hdl/event_flags.sv
// Sticky event flags: hardware set has priority over software clear.
// Assumes set and clear are same-clock one-cycle requests.
`timescale 1ns/1ps
module event_flags #(
  parameter int WIDTH = 26
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] set_req,
  input  wire logic [WIDTH-1:0] clr_req,
  output logic      [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;
  always_comb begin
    flags_nxt = (flags_r & ~clr_req) | set_req;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end
  assign flags = flags_r;
endmodule

// >>> hdl/dma_interrupt_clear.sv
// DMA event logic: raw and masked status, write-one-to-clear register, interrupt.
// Assumes event inputs are one-cycle pulses from DMA logic on mclk.
// Notes on behaviour
// - The clear register sits at offset 1048h, resets to zero, and a one clears the flag.
// - Completion bits 15..0 clear their channel's flag on one and do nothing on zero.
// - A channel's completion flag is latched when its size counter reaches zero.
// - Early-warning flags for channels 0..7 sit in bits 16..23 and each has a clear bit.
// - An unreachable source address latches the bit 24 flag, which has a clear bit.
// - A parity or ECC failure on source data latches the bit 25 flag, with a clear bit.
// - Bits 31..26 of the clear register are reserved, inert and reset to zero.
// - Completion bits of channels that are not implemented have no effect.
// - Every event shows in raw status and, when unmasked, in masked status.
`timescale 1ns/1ps
module dma_interrupt_clear
  import dma_irq_pkg::*;
#(
  parameter int NUM_CHAN = 16
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [DONE_MAX-1:0] size_zero,
  input  wire logic [WARN_N-1:0] warn_hit,
  input  wire logic              addr_fault,
  input  wire logic              data_fault,
  output logic                   irq
);
  localparam logic [DONE_MAX-1:0] CHAN_EN = DONE_MAX'((32'h1 << NUM_CHAN) - 32'h1);
  localparam logic [EVT_W-1:0]    IMPL    = {2'b11, {WARN_N{1'b1}}, CHAN_EN};

  logic              wr_mask;
  logic              wr_clear;
  logic              rd_hit;
  logic [EVT_W-1:0]  set_req;
  logic [EVT_W-1:0]  clr_req;
  logic [EVT_W-1:0]  raw_event_status;
  logic [EVT_W-1:0]  masked_event_status;
  logic [EVT_W-1:0]  mask_r;
  logic [EVT_W-1:0]  mask_nxt;
  logic [DATA_W-1:0] prdata_r;
  logic [DATA_W-1:0] prdata_nxt;
  logic [DATA_W-1:0] interrupt_clear_r;
  logic [DATA_W-1:0] interrupt_clear_nxt;

  apb_decode apb_decode_i (
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pready   (pready),
    .pslverr  (pslverr),
    .wr_mask  (wr_mask),
    .wr_clear (wr_clear),
    .rd_hit   (rd_hit)
  );

  function automatic logic [DATA_W-1:0] widen(input logic [EVT_W-1:0] v);
    widen = {{(DATA_W-EVT_W){1'b0}}, v};
  endfunction

  // Event sources packed in status layout; unimplemented channels stay low
  assign set_req = {data_fault, addr_fault, warn_hit, size_zero & CHAN_EN} & IMPL;

  // Write-one-to-clear; reserved upper bits never reach a flag
  assign clr_req = wr_clear ? (pwdata[EVT_W-1:0] & IMPL) : EVT_ZERO;

  event_flags #(
    .WIDTH (EVT_W)
  ) event_flags_i (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .set_req (set_req),
    .clr_req (clr_req),
    .flags   (raw_event_status)
  );

  assign masked_event_status = raw_event_status & mask_r;

  always_comb begin
    mask_nxt            = wr_mask ? (pwdata[EVT_W-1:0] & IMPL) : mask_r;
    // Clear register is write-only; it holds the written value for one cycle after the write, then returns to zero
    interrupt_clear_nxt = wr_clear ? widen(pwdata[EVT_W-1:0] & IMPL) : CLEAR_RESET;
    prdata_nxt          = WORD_ZERO;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_RAW_STATUS: prdata_nxt = widen(raw_event_status);
        OFS_MASKED:     prdata_nxt = widen(masked_event_status);
        OFS_MASK:       prdata_nxt = widen(mask_r);
        default:        prdata_nxt = WORD_ZERO;
      endcase
    end else if (rd_hit) begin
      prdata_nxt = prdata_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mask_r            <= MASK_RESET[EVT_W-1:0];
      prdata_r          <= WORD_ZERO;
      interrupt_clear_r <= CLEAR_RESET;
    end else begin
      mask_r            <= mask_nxt;
      prdata_r          <= prdata_nxt;
      interrupt_clear_r <= interrupt_clear_nxt;
    end
  end

  assign prdata = prdata_r;
  assign irq    = |masked_event_status;

  sequence s_clear_only(int b);
    wr_clear && pwdata[b] && !set_req[b];
  endsequence

  chk_clear_drops_flag: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_clear && (pwdata[EVT_W-1:0] & IMPL & ~set_req) != EVT_ZERO |=>
      ((raw_event_status & $past(pwdata[EVT_W-1:0] & IMPL & ~set_req)) == EVT_ZERO))
    else $error("written one did not clear flag");
  chk_done_zero_keeps: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_clear && set_req == EVT_ZERO |=>
      ((raw_event_status & ~$past(pwdata[EVT_W-1:0])) == ($past(raw_event_status) & ~$past(pwdata[EVT_W-1:0]))))
    else $error("writing zero changed a flag");
  chk_done_latch: assert property (@(posedge mclk) disable iff (sys_rst)
    size_zero[0] |=> raw_event_status[0] [*1])
    else $error("completion not latched");
  chk_warn_latch: assert property (@(posedge mclk) disable iff (sys_rst)
    warn_hit[0] |=> raw_event_status[WARN_LSB])
    else $error("early warning not latched");
  chk_addr_latch: assert property (@(posedge mclk) disable iff (sys_rst)
    addr_fault |=> raw_event_status[ADDR_FAULT_BIT] && irq == |masked_event_status)
    else $error("address fault not latched");
  chk_data_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    s_clear_only(DATA_FAULT_BIT) |=> !raw_event_status[DATA_FAULT_BIT])
    else $error("data fault not cleared");
  chk_reserved_inert: assert property (@(posedge mclk) disable iff (sys_rst)
    interrupt_clear_r[DATA_W-1:EVT_W] == '0)
    else $error("reserved clear bits set");
  chk_unimpl_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
    (raw_event_status[DONE_MAX-1:0] & ~CHAN_EN) == '0)
    else $error("unimplemented channel flag set");
  chk_masked_view: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(raw_event_status[1]) && mask_r[1] |-> masked_event_status[1] && irq)
    else $error("masked view missing event");
  chk_warn_w1c: assert property (@(posedge mclk) disable iff (sys_rst)
    s_clear_only(WARN_LSB + 1) |=> !raw_event_status[WARN_LSB + 1] ##1 1'b1)
    else $error("early warning not cleared");
  chk_set_wins: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_clear && pwdata[0] && set_req[0] |=> raw_event_status[0])
    else $error("clear beat simultaneous event");
endmodule

// >>> testbench/dma_interrupt_clear_bench.sv
// Self-checking bench for the DMA event clear block, driven over APB.
// Assumes the zero-wait APB slave and one-cycle event pulses of the design.
`timescale 1ns/1ps
module dma_interrupt_clear_bench;
  import dma_irq_pkg::*;
  localparam int NCH = 12;
  logic              mclk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
  logic              addr_fault, data_fault;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, v;
  logic [15:0]       size_zero;
  logic [7:0]        warn_hit;
  logic              e;
  int                error_cnt, compares, cyc;

  dma_interrupt_clear #(.NUM_CHAN(NCH)) dma_interrupt_clear_i (.mclk(mclk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .size_zero(size_zero),
    .warn_hit(warn_hit), .addr_fault(addr_fault), .data_fault(data_fault), .irq(irq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; ev pulses completion events on the edge that ends it
  task automatic apb(input logic wr, input logic [12:0] a, input logic [31:0] d,
                     input logic [15:0] ev, output logic [31:0] rd, output logic err);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1; size_zero <= ev;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0; size_zero <= 16'h0000;
    // Idle cycle so the next request never reassigns a signal in this time step
    @(posedge mclk);
  endtask

  task automatic evt(input logic [15:0] sz, input logic [7:0] wh, input logic af, df);
    size_zero <= sz; warn_hit <= wh; addr_fault <= af; data_fault <= df;
    @(posedge mclk);
    size_zero <= 16'h0000; warn_hit <= 8'h00; addr_fault <= 1'b0; data_fault <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic t_reset;
    apb(0, OFS_CLEAR, 0, 0, v, e); chk(v, 32'h0);
    apb(0, OFS_RAW_STATUS, 0, 0, v, e); chk(v, 32'h0);
    chk({31'h0, e}, 32'h0);
    apb(0, OFS_MASK, 0, 0, v, e); chk(v, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("reset values done");
  endtask

  task automatic t_events;
    evt(16'hffff, 8'hff, 1'b1, 1'b1);
    apb(0, OFS_RAW_STATUS, 0, 0, v, e); chk(v, 32'h03ff_0fff);
    apb(0, OFS_MASKED, 0, 0, v, e); chk(v, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1, OFS_MASK, 32'h03ff_ffff, 0, v, e);
    apb(0, OFS_MASK, 0, 0, v, e); chk(v, 32'h03ff_0fff);
    apb(0, OFS_MASKED, 0, 0, v, e); chk(v, 32'h03ff_0fff);
    chk({31'h0, irq}, 32'h1);
    $display("event latch done");
  endtask

  task automatic t_clear;
    logic [31:0] cw [7];
    logic [31:0] ex [7];
    cw = '{32'h0, 32'hfc00_0000, 32'h0000_f000, 32'h0000_0fff, 32'h00ff_0000,
           32'h0100_0000, 32'h0200_0000};
    ex = '{32'h03ff_0fff, 32'h03ff_0fff, 32'h03ff_0fff, 32'h03ff_0000, 32'h0300_0000,
           32'h0200_0000, 32'h0};
    for (int i = 0; i < 7; i++) begin
      apb(1, OFS_CLEAR, cw[i], 0, v, e);
      apb(0, OFS_RAW_STATUS, 0, 0, v, e); chk(v, ex[i]);
    end
    chk({31'h0, irq}, 32'h0);
    $display("clear sequence done");
  endtask

  task automatic t_race;
    evt(16'h0003, 8'h00, 1'b0, 1'b0);
    apb(1, OFS_CLEAR, 32'h0000_0003, 16'h0001, v, e);
    apb(0, OFS_RAW_STATUS, 0, 0, v, e); chk(v, 32'h0000_0001);
    chk({31'h0, irq}, 32'h1);
    apb(1, 13'h0ff0, 32'hffff_ffff, 0, v, e); chk({31'h0, e}, 32'h1);
    apb(0, OFS_RAW_STATUS, 0, 0, v, e); chk(v, 32'h0000_0001);
    apb(1, OFS_CLEAR, 32'h0000_0001, 0, v, e);
    apb(0, OFS_RAW_STATUS, 0, 0, v, e); chk(v, 32'h0);
    $display("race and unmapped done");
  endtask

  task automatic end_of_test;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    sys_rst = 1'b1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    size_zero = '0; warn_hit = '0; addr_fault = 0; data_fault = 0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_events();
    t_clear();
    t_race();
    end_of_test();
  end
endmodule
